// ===== rtl/rtc_pkg.sv
// constants, types and register map of the serial clock slave
package rtc_pkg;
    // ==========================================================
    // register map
    localparam int MEM_DEPTH = 64;
    localparam int PTR_W = 6;
    localparam logic [5:0] OFS_SECONDS = 6'h00;
    localparam logic [5:0] OFS_MINUTES = 6'h01;
    localparam logic [5:0] OFS_HOURS = 6'h02;
    localparam logic [5:0] OFS_WEEKDAY = 6'h03;
    localparam logic [5:0] OFS_DAY_OF_MONTH = 6'h04;
    localparam logic [5:0] OFS_MONTH = 6'h05;
    localparam logic [5:0] OFS_YEAR = 6'h06;
    localparam logic [5:0] OFS_WAVE_CTRL = 6'h07;
    localparam logic [5:0] OFS_RAM_FIRST = 6'h08;
    localparam logic [5:0] OFS_RAM_LAST = 6'h3F;
    // ==========================================================
    // field positions
    localparam int HALT_BIT = 7;
    localparam int HOUR_FMT_BIT = 6;
    localparam int HOUR_PM_BIT = 5;
    localparam int CTRL_OUT_BIT = 7;
    localparam int CTRL_WAVE_EN_BIT = 4;
    localparam int CTRL_RS_HI_BIT = 1;
    localparam int CTRL_RS_LO_BIT = 0;
    // ==========================================================
    // reset values
    localparam logic [7:0] SECONDS_RST = 8'h80;
    localparam logic [7:0] MEM_RST = 8'h00;
    // ==========================================================
    // bus encodings
    localparam logic RW_WRITE = 1'b0;
    localparam logic RW_READ = 1'b1;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    // ==========================================================
    // square wave rates and divider taps
    localparam int OSC_HZ = 65536;
    localparam int DIV_W = $clog2(OSC_HZ);
    localparam logic [1:0] RATE_1HZ = 2'b00;
    localparam logic [1:0] RATE_4K = 2'b01;
    localparam logic [1:0] RATE_8K = 2'b10;
    localparam logic [1:0] RATE_32K = 2'b11;
    localparam int TAP_1HZ = $clog2(OSC_HZ / 1) - 1;
    localparam int TAP_4K = $clog2(OSC_HZ / 4096) - 1;
    localparam int TAP_8K = $clog2(OSC_HZ / 8192) - 1;
    localparam int TAP_32K = $clog2(OSC_HZ / 32768) - 1;
    // ==========================================================
    // types
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_RX = 3'b001,
        ST_RX_ACK = 3'b010,
        ST_TX = 3'b011,
        ST_TX_ACK = 3'b100
    } rtc_state_e;
    typedef enum logic [1:0] {
        KIND_ADDR = 2'b00,
        KIND_PTR = 2'b01,
        KIND_DATA = 2'b10
    } rtc_kind_e;
    typedef struct packed {
        logic halt;
        logic out_level;
        logic wave_enable;
        logic [1:0] rate;
    } rtc_ctrl_s;
    typedef struct packed {
        logic scl;
        logic sda;
    } rtc_bus_s;
endpackage

// ===== rtl/rtc_top.sv
// two-wire clock slave: bus engine, register memory and square wave output
module rtc_top #(
    parameter logic [6:0] DEV_ID = 7'h2A // arbitrary value
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic clk_osc,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    output logic wave_output_pin
);
    import rtc_pkg::*;

    // ==========================================================
    // pin synchronisers and bus event detection
    rtc_bus_s pin_meta_q;
    rtc_bus_s pin_sync_q;
    rtc_bus_s pin_prev_q;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pin_meta_q <= '{scl: 1'b1, sda: 1'b1};
            pin_sync_q <= '{scl: 1'b1, sda: 1'b1};
            pin_prev_q <= '{scl: 1'b1, sda: 1'b1};
        end else begin
            pin_meta_q <= '{scl: scl_i, sda: sda_i};
            pin_sync_q <= pin_meta_q;
            pin_prev_q <= pin_sync_q;
        end
    end

    // slave only: every edge comes from the master
    assign scl_rise = pin_sync_q.scl & ~pin_prev_q.scl;
    assign scl_fall = ~pin_sync_q.scl & pin_prev_q.scl;
    assign start_det = pin_sync_q.scl & pin_prev_q.scl & pin_prev_q.sda & ~pin_sync_q.sda;
    assign stop_det = pin_sync_q.scl & pin_prev_q.scl & ~pin_prev_q.sda & pin_sync_q.sda;

    // ==========================================================
    // transaction engine
    rtc_state_e state_q;
    rtc_kind_e kind_q;
    logic [3:0] bit_cnt_q;
    logic [7:0] shift_q;
    logic [7:0] tx_q;
    logic read_q;
    logic master_ack_q;
    logic [PTR_W-1:0] ptr_q;
    logic [7:0] mem_q [MEM_DEPTH];
    logic byte_done;
    logic addr_ok;
    logic ack_end;
    logic tx_load;
    logic tx_shift;
    logic tx_done;
    logic [7:0] tx_word;

    assign byte_done = (state_q == ST_RX) && scl_fall && (bit_cnt_q == BITS_PER_BYTE);
    assign addr_ok = (shift_q[7:1] == DEV_ID);
    assign ack_end = (state_q == ST_RX_ACK) && scl_fall;
    assign tx_load = (ack_end && read_q) || ((state_q == ST_TX_ACK) && scl_fall && master_ack_q);
    assign tx_shift = (state_q == ST_TX) && scl_fall && (bit_cnt_q != BITS_PER_BYTE);
    assign tx_done = (state_q == ST_TX) && scl_fall && (bit_cnt_q == BITS_PER_BYTE);
    assign tx_word = mem_q[ptr_q];

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_q <= ST_IDLE;
            kind_q <= KIND_ADDR;
            bit_cnt_q <= 4'h0;
            shift_q <= 8'h00;
            read_q <= RW_WRITE;
            master_ack_q <= 1'b0;
        end else if (start_det) begin
            state_q <= ST_RX;
            kind_q <= KIND_ADDR;
            bit_cnt_q <= 4'h0;
        end else if (stop_det) begin
            state_q <= ST_IDLE;
        end else begin
            case (state_q)
                ST_RX: begin
                    if (scl_rise) begin
                        shift_q <= {shift_q[6:0], pin_sync_q.sda};
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                    end else if (byte_done) begin
                        if (kind_q == KIND_ADDR && !addr_ok) begin
                            state_q <= ST_IDLE;
                        end else begin
                            state_q <= ST_RX_ACK;
                            if (kind_q == KIND_ADDR) begin
                                read_q <= shift_q[0];
                            end
                        end
                    end
                end
                ST_RX_ACK: begin
                    if (ack_end) begin
                        bit_cnt_q <= 4'h0;
                        if (read_q == RW_READ) begin
                            state_q <= ST_TX;
                        end else begin
                            state_q <= ST_RX;
                            kind_q <= (kind_q == KIND_ADDR) ? KIND_PTR : KIND_DATA;
                        end
                    end
                end
                ST_TX: begin
                    if (scl_rise) begin
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                    end else if (tx_done) begin
                        state_q <= ST_TX_ACK;
                    end
                end
                ST_TX_ACK: begin
                    if (scl_rise) begin
                        master_ack_q <= ~pin_sync_q.sda;
                    end else if (scl_fall) begin
                        bit_cnt_q <= 4'h0;
                        state_q <= master_ack_q ? ST_TX : ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // serial data drive, open drain, low only
    logic sda_oe_q;
    logic sda_o_q;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sda_oe_q <= 1'b0;
            sda_o_q <= 1'b0;
            tx_q <= 8'h00;
        end else if (start_det || stop_det) begin
            sda_oe_q <= 1'b0;
        end else if (byte_done) begin
            sda_oe_q <= (kind_q != KIND_ADDR) || addr_ok;
        end else if (tx_load) begin
            tx_q <= tx_word;
            sda_oe_q <= ~tx_word[7];
        end else if (tx_shift) begin
            tx_q <= {tx_q[6:0], 1'b0};
            sda_oe_q <= ~tx_q[6];
        end else if (ack_end || tx_done || (state_q == ST_TX_ACK && scl_fall)) begin
            sda_oe_q <= 1'b0;
        end
    end

    assign sda_o = sda_o_q;
    assign sda_oe = sda_oe_q;

    // ==========================================================
    // address pointer
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ptr_q <= OFS_SECONDS;
        end else if (byte_done && kind_q == KIND_PTR) begin
            ptr_q <= shift_q[PTR_W-1:0];
        end else if ((byte_done && kind_q == KIND_DATA) || tx_load) begin
            ptr_q <= ptr_q + 6'h01;
        end
    end

    // ==========================================================
    // register and ram memory
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            for (int i = 0; i < MEM_DEPTH; i++) begin
                mem_q[i] <= (PTR_W'(i) == OFS_SECONDS) ? SECONDS_RST : MEM_RST;
            end
        end else if (byte_done && kind_q == KIND_DATA) begin
            // bcd time fields, hour mode bits and ram kept as written
            mem_q[ptr_q] <= shift_q;
        end
    end

    // ==========================================================
    // control snapshot handed to the oscillator domain
    rtc_ctrl_s ctrl_src_q;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ctrl_src_q <= '{halt: SECONDS_RST[HALT_BIT], out_level: MEM_RST[CTRL_OUT_BIT],
                            wave_enable: MEM_RST[CTRL_WAVE_EN_BIT], rate: RATE_1HZ};
        end else begin
            ctrl_src_q.halt <= mem_q[OFS_SECONDS][HALT_BIT];
            ctrl_src_q.out_level <= mem_q[OFS_WAVE_CTRL][CTRL_OUT_BIT];
            ctrl_src_q.wave_enable <= mem_q[OFS_WAVE_CTRL][CTRL_WAVE_EN_BIT];
            ctrl_src_q.rate <= {mem_q[OFS_WAVE_CTRL][CTRL_RS_HI_BIT],
                                mem_q[OFS_WAVE_CTRL][CTRL_RS_LO_BIT]};
        end
    end

    // ==========================================================
    // oscillator domain: reset and control synchronisers
    logic rst_osc_meta_q;
    logic rst_osc_q;
    rtc_ctrl_s ctrl_meta_q;
    rtc_ctrl_s ctrl_osc_q;

    always_ff @(posedge clk_osc) begin
        rst_osc_meta_q <= rst;
        rst_osc_q <= rst_osc_meta_q;
    end

    always_ff @(posedge clk_osc) begin
        ctrl_meta_q <= ctrl_src_q;
        ctrl_osc_q <= ctrl_meta_q;
    end

    // ==========================================================
    // divider and square wave pin
    logic [DIV_W-1:0] div_q;
    logic wave_tap;
    logic wave_pin_q;

    always_ff @(posedge clk_osc) begin
        if (rst_osc_q || ctrl_osc_q.halt) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 1'b1;
        end
    end

    always_comb begin
        case (ctrl_osc_q.rate)
            RATE_1HZ: wave_tap = div_q[TAP_1HZ];
            RATE_4K: wave_tap = div_q[TAP_4K];
            RATE_8K: wave_tap = div_q[TAP_8K];
            RATE_32K: wave_tap = div_q[TAP_32K];
            default: wave_tap = 1'b0;
        endcase
    end

    always_ff @(posedge clk_osc) begin
        if (rst_osc_q) begin
            wave_pin_q <= MEM_RST[CTRL_OUT_BIT];
        end else if (ctrl_osc_q.wave_enable) begin
            wave_pin_q <= wave_tap;
        end else begin
            wave_pin_q <= ctrl_osc_q.out_level;
        end
    end

    assign wave_output_pin = wave_pin_q;
endmodule

// ===== sim/rtc_chk.sv
// bus pin assertions for the serial clock slave
module rtc_chk (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic clk_osc,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe,
    input wire logic wave_output_pin
);
    logic seen_start_q;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    // ==========================================================
    // bus events
    sequence start_seen;
        scl_i && $fell(sda_i);
    endsequence
    sequence stop_seen;
        scl_i && $rose(sda_i);
    endsequence
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            seen_start_q <= 1'b0;
        end else if (scl_i && $fell(sda_i)) begin
            seen_start_q <= 1'b1;
        end
    end
    // ==========================================================
    // assertions
    drive_low_a: assert property (sda_oe |-> !sda_o)
        else $error("sda driven high");
    start_first_a: assert property (!seen_start_q |-> !sda_oe)
        else $error("drive before start");
    start_free_a: assert property (start_seen |-> (!sda_oe) [*3])
        else $error("drive at start");
    stop_release_a: assert property (stop_seen |-> (!sda_oe) [*8])
        else $error("drive after stop");
    stable_high_a: assert property (scl_i && $past(scl_i) |-> $stable(sda_oe))
        else $error("data moved while clock high");
    ack_hold_a: assert property ($rose(scl_i) && sda_oe |-> sda_oe [*8])
        else $error("low not held in clock high");
    rise_delay_a: assert property ($rose(sda_oe) |-> !scl_i && $past(scl_i, 7))
        else $error("late or misplaced drive");
    fall_delay_a: assert property ($fell(sda_oe) |-> !scl_i && $past(scl_i, 7))
        else $error("late or misplaced release");
endmodule
bind rtc_top rtc_chk chk (
    .clk_sys(clk_sys),
    .rst(rst),
    .clk_osc(clk_osc),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .sda_o(sda_o),
    .sda_oe(sda_oe),
    .wave_output_pin(wave_output_pin)
);

// ===== sim/rtc_master.sv
// two-wire bus master model: clock and open-drain data
module rtc_master (
    input wire logic clk_sys,
    input wire logic sda_w,
    output logic scl,
    output logic sda_rel
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        scl = 1'b1;
        sda_rel = 1'b1;
    end
    // ==========================================================
    // bus phases
    task automatic q();
        repeat (25) @(posedge clk_sys);
        #1;
    endtask
    task automatic m_start();
        sda_rel = 1'b1;
        q();
        scl = 1'b1;
        q();
        sda_rel = 1'b0;
        q();
        scl = 1'b0;
        q();
    endtask
    task automatic m_stop();
        sda_rel = 1'b0;
        q();
        scl = 1'b1;
        q();
        sda_rel = 1'b1;
        q();
    endtask
    task automatic m_bit(input logic b, output logic r);
        sda_rel = b;
        q();
        scl = 1'b1;
        q();
        r = sda_w;
        q();
        scl = 1'b0;
        q();
    endtask
    task automatic m_tx(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            m_bit(d[i], r);
        end
        m_bit(1'b1, ack);
    endtask
    task automatic m_rx(output logic [7:0] d, input logic last);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            m_bit(1'b1, d[i]);
        end
        m_bit(last, r);
    endtask
endmodule

// ===== sim/tb_top.sv
// self-checking bench for the serial clock slave
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import rtc_pkg::*;
    localparam logic [6:0] ID = 7'h2A; // arbitrary value
    logic clk_sys = 1'b0;
    logic clk_osc = 1'b0;
    logic rst = 1'b1;
    logic scl, sda_rel, sda_o, sda_oe, wave_output_pin, sda_w;
    logic wave_prev = 1'b0;
    int fail_count = 0;
    int checks = 0;
    int toggles = 0;
    int exp_t[4] = '{0, 8, 16, 64};
    assign sda_w = sda_rel & ~(sda_oe & ~sda_o);
    always #50 clk_sys = ~clk_sys;
    always #15 clk_osc = ~clk_osc;
    always @(posedge clk_osc) begin
        if (wave_output_pin !== wave_prev) toggles++;
        wave_prev <= wave_output_pin;
    end
    rtc_top #(.DEV_ID(ID)) uut (.clk_sys(clk_sys), .rst(rst), .clk_osc(clk_osc),
        .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe),
        .wave_output_pin(wave_output_pin));
    rtc_master mst (.clk_sys(clk_sys), .sda_w(sda_w), .scl(scl), .sda_rel(sda_rel));
    // ==========================================================
    // helpers
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %0t got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic results();
        if (fail_count == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic wr(input logic [7:0] p, input logic [7:0] d[$]);
        logic a;
        mst.m_start();
        mst.m_tx({ID, RW_WRITE}, a);
        check({7'h00, a}, 8'h00);
        mst.m_tx(p, a);
        check({7'h00, a}, 8'h00);
        foreach (d[i]) begin
            mst.m_tx(d[i], a);
            check({7'h00, a}, 8'h00);
        end
        mst.m_stop();
    endtask
    task automatic rd_check(input logic [7:0] p, input logic [7:0] exp[$]);
        logic a;
        logic [7:0] b;
        wr(p, '{});
        mst.m_start();
        mst.m_tx({ID, RW_READ}, a);
        check({7'h00, a}, 8'h00);
        foreach (exp[i]) begin
            mst.m_rx(b, i == exp.size() - 1);
            check(b, exp[i]);
        end
        mst.m_stop();
    endtask
    // ==========================================================
    // scenarios
    task automatic t_time();
        wr(8'h00, '{8'h00, 8'h59, 8'h72, 8'h06, 8'h20, 8'h06, 8'h98});
        rd_check(8'h00, '{8'h00, 8'h59, 8'h72, 8'h06, 8'h20, 8'h06, 8'h98});
    endtask
    task automatic t_foreign();
        logic a;
        mst.m_start();
        mst.m_tx({ID ^ 7'h01, RW_WRITE}, a);
        check({7'h00, a}, 8'h01);
        mst.m_tx(8'h07, a);
        check({7'h00, a}, 8'h01);
        mst.m_stop();
    endtask
    task automatic t_wave();
        wr(8'h07, '{8'h80});
        repeat (20) @(posedge clk_sys);
        check({7'h00, wave_output_pin}, 8'h01);
        wr(8'h07, '{8'h00});
        repeat (20) @(posedge clk_sys);
        check({7'h00, wave_output_pin}, 8'h00);
        for (int r = 0; r < 4; r++) begin
            wr(8'h07, '{{6'h04, r[1:0]}});
            repeat (20) @(posedge clk_sys);
            toggles = 0;
            repeat (64) @(posedge clk_osc);
            check({7'h00, toggles >= exp_t[r] - 1 && toggles <= exp_t[r] + 1}, 8'h01);
        end
        wr(8'h00, '{8'h80});
        repeat (20) @(posedge clk_sys);
        toggles = 0;
        repeat (64) @(posedge clk_osc);
        check({7'h00, toggles == 0}, 8'h01);
    endtask
    initial begin
        repeat (12) @(posedge clk_sys);
        #1 rst = 1'b0;
        repeat (10) @(posedge clk_sys);
        rd_check(8'h00, '{8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
        t_time();
        wr(8'h3E, '{8'hA5, 8'h5A, 8'h43});
        rd_check(8'h3E, '{8'hA5, 8'h5A, 8'h43});
        t_foreign();
        t_wave();
        results();
    end
    initial begin
        #10_000_000;
        fail_count++;
        results();
    end
endmodule
